/* common/pdrl_defines.vh */
`ifndef PDRL_DEFINES_VH
`define PDRL_DEFINES_VH

// register indexes; byte address is four times the index
`define PDRL_IDX_AC12 8'h1A
`define PDRL_IDX_AC34 8'h1B
`define PDRL_IDX_CFG1 8'h21
`define PDRL_IDX_CFG2 8'h22
`define PDRL_IDX_CFG3 8'h23
`define PDRL_IDX_CFG4 8'h24
`define PDRL_IDX_DUTY1 8'h30
`define PDRL_IDX_DUTY2 8'h31
`define PDRL_IDX_DUTY3 8'h32
`define PDRL_IDX_DUTY4 8'h33

// field positions
`define PDRL_EN_LO 0
`define PDRL_EN_HI 1
`define PDRL_RR_LO_MSB 4
`define PDRL_RR_LO_LSB 2
`define PDRL_RR_HI_MSB 7
`define PDRL_RR_HI_LSB 5
`define PDRL_SLOW_BIT 3

// reset values
`define PDRL_AC_RST 8'h00
`define PDRL_SLOW_RST 1'b0
`define PDRL_DUTY_RST 8'h00

// timing
`define PDRL_LAST_SLOT 8'hFE
`define PDRL_FULL_DUTY 8'hFF
`define PDRL_SLOW_LAST 2'h3

// step sizes in slots, codes 000..111
`define PDRL_STEP_0 8'h01
`define PDRL_STEP_1 8'h02
`define PDRL_STEP_2 8'h03
`define PDRL_STEP_3 8'h05
`define PDRL_STEP_4 8'h08
`define PDRL_STEP_5 8'h0C
`define PDRL_STEP_6 8'h18
`define PDRL_STEP_7 8'h30

`endif

/* rtl/pdrl_top.v */
// Overview of operation
// - enable bit 0 of register one turns on ramp limiting for output one.
// - enable bit 1 of register one turns on ramp limiting for output two.
// - enable bit 0 of register two turns on ramp limiting for output three.
// - enable bit 1 of register two turns on ramp limiting for output four.
// - each pwm period has 255 slots; duty is a count of high slots.
// - target above applied duty: raise applied duty by the selected step.
// - target below applied duty: lower applied duty by the selected step.
// - the stepped result becomes the previous duty for the next comparison.
// - output one step field bits 4:2 decode to 1,2,3,5,8,12,24,48 slots.
// - output two step field sits in bits 7:5 of register one.
// - limiting acts per output, independent of other outputs.
// - limiting off: applied duty follows the target at once.
// - outputs three and four steps sit in bits 4:2 and 7:5 of register two.
// - slow bit 3 in an output config register slows its ramp four times.
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pdrl_defines.vh"

module pdrl_top #(
    parameter SLOT_DIV = 4 // pclk cycles per pwm slot
)(
    input wire pclk, // system clock, 250 MHz
    input wire presetn, // asynchronous reset, active low
    input wire ce, // clock enable, freezes all state when low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction, high for write
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error, unmapped address
    input wire duty_update, // one-cycle pulse, new targets valid
    input wire [7:0] target_duty_1, // calculated duty for output one
    input wire [7:0] target_duty_2, // calculated duty for output two
    input wire [7:0] target_duty_3, // calculated duty for output three
    input wire [7:0] target_duty_4, // calculated duty for output four
    output wire fan_drive_1, // pwm output one
    output wire fan_drive_2, // pwm output two
    output wire fan_drive_3, // pwm output three
    output wire fan_drive_4 // pwm output four
);

    reg [7:0] acoustic_ctrl_out12;
    reg [7:0] acoustic_ctrl_out34;
    reg [3:0] slow_ramp;
    reg [7:0] applied [0:3];
    reg [7:0] period_duty [0:3];
    reg [1:0] slow_cnt [0:3];
    reg [3:0] drive;
    reg [7:0] slot;
    reg [15:0] div_cnt;

    wire [7:0] target [0:3];
    wire [3:0] limit_on;
    wire [2:0] rate_code [0:3];
    wire [7:0] idx;
    wire access_hit;
    wire wr_take;
    wire slot_tick;
    wire period_end;
    reg [31:0] rd_mux;
    reg rd_ok;

    assign target[0] = target_duty_1;
    assign target[1] = target_duty_2;
    assign target[2] = target_duty_3;
    assign target[3] = target_duty_4;

    assign limit_on[0] = acoustic_ctrl_out12[`PDRL_EN_LO];
    assign limit_on[1] = acoustic_ctrl_out12[`PDRL_EN_HI];
    assign limit_on[2] = acoustic_ctrl_out34[`PDRL_EN_LO];
    assign limit_on[3] = acoustic_ctrl_out34[`PDRL_EN_HI];

    assign rate_code[0] = acoustic_ctrl_out12[`PDRL_RR_LO_MSB:`PDRL_RR_LO_LSB];
    assign rate_code[1] = acoustic_ctrl_out12[`PDRL_RR_HI_MSB:`PDRL_RR_HI_LSB];
    assign rate_code[2] = acoustic_ctrl_out34[`PDRL_RR_LO_MSB:`PDRL_RR_LO_LSB];
    assign rate_code[3] = acoustic_ctrl_out34[`PDRL_RR_HI_MSB:`PDRL_RR_HI_LSB];

    assign fan_drive_1 = drive[0];
    assign fan_drive_2 = drive[1];
    assign fan_drive_3 = drive[2];
    assign fan_drive_4 = drive[3];

    function [7:0] step_of;
        input [2:0] code;
        begin
            case (code)
                3'h0: step_of = `PDRL_STEP_0;
                3'h1: step_of = `PDRL_STEP_1;
                3'h2: step_of = `PDRL_STEP_2;
                3'h3: step_of = `PDRL_STEP_3;
                3'h4: step_of = `PDRL_STEP_4;
                3'h5: step_of = `PDRL_STEP_5;
                3'h6: step_of = `PDRL_STEP_6;
                default: step_of = `PDRL_STEP_7;
            endcase
        end
    endfunction

    // one limited move from the previous duty toward the target
    function [7:0] ramp_to;
        input [7:0] prev;
        input [7:0] tgt;
        input [7:0] step;
        reg [7:0] gap;
        begin
            gap = 8'h00;
            // gap compared before the add, so the sum can never pass 255
            if (tgt > prev)
            begin
                gap = tgt - prev;
                if (gap > step)
                begin
                    ramp_to = prev + step;
                end
                else
                begin
                    ramp_to = tgt;
                end
            end
            else if (tgt < prev)
            begin
                gap = prev - tgt;
                if (gap > step)
                begin
                    ramp_to = prev - step;
                end
                else
                begin
                    ramp_to = tgt;
                end
            end
            else
            begin
                ramp_to = prev;
            end
        end
    endfunction

    // apb: one wait state, answer registered so all outputs come from flops
    assign idx = paddr[9:2];
    assign access_hit = psel & penable & ~pready;
    assign wr_take = psel & penable & pready & pwrite & ~pslverr;

    always @*
    begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0)
            rd_ok = 1'b0;
        else
        begin
            case (idx)
                `PDRL_IDX_AC12:
                begin
                    rd_mux[7:0] = acoustic_ctrl_out12;
                end
                `PDRL_IDX_AC34:
                begin
                    rd_mux[7:0] = acoustic_ctrl_out34;
                end
                // config registers hold only the slow bit; the rest reads zero
                `PDRL_IDX_CFG1:
                begin
                    rd_mux[`PDRL_SLOW_BIT] = slow_ramp[0];
                end
                `PDRL_IDX_CFG2:
                begin
                    rd_mux[`PDRL_SLOW_BIT] = slow_ramp[1];
                end
                `PDRL_IDX_CFG3:
                begin
                    rd_mux[`PDRL_SLOW_BIT] = slow_ramp[2];
                end
                `PDRL_IDX_CFG4:
                begin
                    rd_mux[`PDRL_SLOW_BIT] = slow_ramp[3];
                end
                `PDRL_IDX_DUTY1:
                begin
                    rd_mux[7:0] = applied[0];
                end
                `PDRL_IDX_DUTY2:
                begin
                    rd_mux[7:0] = applied[1];
                end
                `PDRL_IDX_DUTY3:
                begin
                    rd_mux[7:0] = applied[2];
                end
                `PDRL_IDX_DUTY4:
                begin
                    rd_mux[7:0] = applied[3];
                end
                default:
                begin
                    rd_ok = 1'b0;
                end
            endcase
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready <= access_hit;
            pslverr <= access_hit & ~rd_ok;
            if (access_hit && !pwrite)
                prdata <= rd_mux;
            else if (access_hit)
                prdata <= 32'h0000_0000;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acoustic_ctrl_out12 <= `PDRL_AC_RST;
            acoustic_ctrl_out34 <= `PDRL_AC_RST;
            slow_ramp <= {4{`PDRL_SLOW_RST}};
        end
        else if (ce && wr_take)
        begin
            case (idx)
                `PDRL_IDX_AC12:
                begin
                    acoustic_ctrl_out12 <= pwdata[7:0];
                end
                `PDRL_IDX_AC34:
                begin
                    acoustic_ctrl_out34 <= pwdata[7:0];
                end
                `PDRL_IDX_CFG1:
                begin
                    slow_ramp[0] <= pwdata[`PDRL_SLOW_BIT];
                end
                `PDRL_IDX_CFG2:
                begin
                    slow_ramp[1] <= pwdata[`PDRL_SLOW_BIT];
                end
                `PDRL_IDX_CFG3:
                begin
                    slow_ramp[2] <= pwdata[`PDRL_SLOW_BIT];
                end
                `PDRL_IDX_CFG4:
                begin
                    slow_ramp[3] <= pwdata[`PDRL_SLOW_BIT];
                end
                // duty status words are read-only; a write there is dropped quietly
                default:
                begin
                    acoustic_ctrl_out12 <= acoustic_ctrl_out12;
                end
            endcase
        end
    end

    // slot timebase shared by all outputs
    assign slot_tick = (div_cnt == SLOT_DIV[15:0] - 16'h0001);
    assign period_end = slot_tick && (slot == `PDRL_LAST_SLOT);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt <= 16'h0000;
            slot <= 8'h00;
        end
        else if (ce)
        begin
            if (slot_tick)
            begin
                div_cnt <= 16'h0000;
                if (slot == `PDRL_LAST_SLOT)
                begin
                    slot <= 8'h00;
                end
                else
                begin
                    slot <= slot + 8'h01;
                end
            end
            else
                div_cnt <= div_cnt + 16'h0001;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : chan
            // with limiting on, slow mode lets only every fourth update move the duty
            wire move = ~slow_ramp[g] | (slow_cnt[g] == `PDRL_SLOW_LAST);

            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    applied[g] <= `PDRL_DUTY_RST;
                    slow_cnt[g] <= 2'h0;
                end
                else if (ce && duty_update)
                begin
                    slow_cnt[g] <= slow_cnt[g] + 2'h1;
                    if (!limit_on[g])
                        applied[g] <= target[g];
                    else if (move)
                        applied[g] <= ramp_to(applied[g], target[g], step_of(rate_code[g]));
                end
            end

            // duty sampled once a period so a mid-period change cannot glitch the pulse
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    period_duty[g] <= `PDRL_DUTY_RST;
                    drive[g] <= 1'b0;
                end
                else if (ce)
                begin
                    if (period_end)
                    begin
                        period_duty[g] <= applied[g];
                    end
                    drive[g] <= (period_duty[g] == `PDRL_FULL_DUTY) | (slot < period_duty[g]);
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

/* verification/pdrl_fan_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pdrl_fan_model (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic drive, // pwm drive into the fan
    output logic [31:0] high_cycles // clocks seen with drive high
);
    // a fan only integrates its drive; over one period the count is the duty times SLOT_DIV
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            high_cycles <= 32'h0;
        else
            high_cycles <= high_cycles + {31'h0, drive};
    end
endmodule
`default_nettype wire

/* verification/pdrl_top_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module pdrl_top_checker #(
    parameter SLOT_DIV = 4
)(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic fan_drive_1 // pwm output one
);
    logic [31:0] since;
    logic seen;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_first_access;
        psel && penable && !pready;
    endsequence
    // rising edges only at period starts, so gaps are whole periods
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            since <= 32'h0;
            seen <= 1'b0;
        end
        else
        begin
            since <= $rose(fan_drive_1) ? 32'h1 : since + 32'h1;
            seen <= seen | $rose(fan_drive_1);
        end
    end
    ready_one_cycle_a: assert property (pready |=> !pready) else $error("pready held too long");
    one_wait_state_a: assert property (apb_setup ##1 apb_first_access |=> pready)
        else $error("apb answer not after one wait state");
    ready_has_cause_a: assert property (pready |-> psel && penable) else $error("pready without access");
    error_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr outside answer");
    bad_address_err_a: assert property (pready && (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) |-> pslverr)
        else $error("bad address not refused");
    write_rdata_zero_a: assert property (pready && pwrite |-> prdata == 32'h0) else $error("read data on write");
    read_upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
    pwm_period_a: assert property ($rose(fan_drive_1) && seen |-> since % (255 * SLOT_DIV) == 0)
        else $error("pwm rise off period grid");
endmodule
bind pdrl_top pdrl_top_checker #(.SLOT_DIV(SLOT_DIV)) u_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fan_drive_1(fan_drive_1));
`default_nettype wire

/* verification/pdrl_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module pdrl_top_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, duty_update = 1'b0, rerr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, h0;
    logic [7:0] tgt = 8'h00;
    logic [7:0] prev [4];
    logic [7:0] ac [2];
    logic [7:0] steps [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
    logic [7:0] tgts [4] = '{8'hC8, 8'hC8, 8'h00, 8'h32};
    wire [31:0] prdata, high_cycles;
    wire pready, pslverr;
    wire [3:0] drv;
    integer error_cnt = 0, samples_checked = 0, n, c, k, i;
    always #2 pclk = ~pclk;
    pdrl_top #(.SLOT_DIV(1)) dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .duty_update(duty_update), .target_duty_1(tgt), .target_duty_2(tgt), .target_duty_3(tgt),
        .target_duty_4(tgt), .fan_drive_1(drv[0]), .fan_drive_2(drv[1]), .fan_drive_3(drv[2]),
        .fan_drive_4(drv[3]));
    pdrl_fan_model u_fan (.pclk(pclk), .presetn(presetn), .drive(drv[0]), .high_cycles(high_cycles));
    task end_sim;
        $display("errors=%0d checks=%0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task rst;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    // request held until the edge where pready is sampled high
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n = n + 1;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            error_cnt = error_cnt + 1;
            end_sim;
        end
        rd = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task upd(input [7:0] t);
        @(posedge pclk);
        tgt <= t;
        duty_update <= 1'b1;
        @(posedge pclk);
        duty_update <= 1'b0;
    endtask
    function automatic [7:0] nx(input [7:0] p, input [7:0] t, input en, input [7:0] s);
        if (!en || t == p)
            nx = t;
        else if (t > p)
            nx = (t - p <= s) ? t : p + s;
        else
            nx = (p - t <= s) ? t : p - s;
    endfunction
    initial
    begin
        rst;
        apb(1'b0, 12'h068, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h06C, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h070, 32'h0);
        chk(rerr, 32'h1);
        apb(1'b1, 12'h069, 32'hFF);
        chk(rerr, 32'h1);
        for (c = 0; c < 8; c = c + 1)
        begin
            apb(1'b1, 12'h068, 32'h0);
            apb(1'b1, 12'h06C, 32'h0);
            upd(8'h00);
            for (i = 0; i < 4; i = i + 1)
                prev[i] = 8'h00;
            ac[0] = {3'(7 - c), 3'(c), 2'b11};
            ac[1] = {3'(c), 3'(7 - c), c[0], ~c[0]};
            apb(1'b1, 12'h068, {24'h0, ac[0]});
            apb(1'b1, 12'h06C, {24'h0, ac[1]});
            apb(1'b0, 12'h06C, 32'h0);
            chk(rd, {24'h0, ac[1]});
            for (k = 0; k < 4; k = k + 1)
            begin
                upd(tgts[k]);
                for (i = 0; i < 4; i = i + 1)
                begin
                    prev[i] = nx(prev[i], tgts[k], ac[i / 2][i % 2],
                        steps[(i % 2) ? ac[i / 2][7:5] : ac[i / 2][4:2]]);
                    apb(1'b0, 12'hC0 + 12'(4 * i), 32'h0);
                    chk(rd, {24'h0, prev[i]});
                end
            end
        end
        apb(1'b1, 12'h068, 32'h0);
        upd(8'h55);
        repeat (600) @(posedge pclk);
        h0 = high_cycles;
        for (i = 0; i < 255; i = i + 1)
        begin
            @(posedge pclk);
            chk({28'h0, drv}, {28'h0, {4{drv[0]}}});
        end
        chk(high_cycles - h0, 32'h55);
        rst;
        apb(1'b1, 12'h084, 32'hFF);
        apb(1'b0, 12'h084, 32'h0);
        chk(rd, 32'h8);
        apb(1'b1, 12'h068, 32'h1D);
        for (k = 1; k < 3; k = k + 1)
        begin
            repeat (4) upd(8'hC8);
            apb(1'b0, 12'h0C0, 32'h0);
            chk(rd, 32'h30 * k);
        end
        end_sim;
    end
endmodule
`default_nettype wire
